// ---- vro_pkg.sv ----
// Constants and types shared by the voltage restrained overcurrent block
//
// Contract
// - Restrained mode, voltage at or above upper limit: pickup equals base current.
// - Restrained mode, voltage below lower limit: pickup is base times percent over 100.
// - Restrained mode, between limits: pickup rises linearly from reduced to base.
// - Equal limits accepted; pickup steps from reduced to base at that voltage.
// - Lower limit above upper blocks function with warning until corrected load.
// - No start or trip unless operation enable is on.
// - Each phase uses its own voltage to set its own threshold.
// - Three phase start flags, each set while current exceeds its threshold.
// - One general trip output carries the trip command.
// - Any active blocking input suppresses all start and trip outputs.
// - Controlled mode: start only below lower limit and above base current.
// - Trip once start has persisted for the configured delay.
package vro_pkg;

   // ----------------------------------------------------------------
   // Widths
   // ----------------------------------------------------------------
   localparam int MAG_W   = 16;
   localparam int PCT_W   = 7;
   localparam int DELAY_W = 16;
   localparam int PROD_W  = 32;

   // ----------------------------------------------------------------
   // Setting reset values, used until the first load
   // ----------------------------------------------------------------
   localparam logic [MAG_W-1:0]   BASE_RST   = 16'hffff;
   localparam logic [PCT_W-1:0]   PCT_RST    = 7'h64;
   localparam logic [MAG_W-1:0]   U_LOW_RST  = 16'h0000;
   localparam logic [MAG_W-1:0]   U_HIGH_RST = 16'h0000;
   localparam logic [DELAY_W-1:0] DELAY_RST  = 16'h0064;
   localparam logic [PCT_W-1:0]   PCT_MAX    = 7'h64;
   localparam logic [PCT_W-1:0]   PCT_DIV    = 7'h64;

   // ----------------------------------------------------------------
   // Timing
   // ----------------------------------------------------------------
   localparam int MS_NS          = 1000000;
   localparam int CLK_PERIOD_NS  = 20;
   localparam int MS_TICK_CYCLES = (MS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int TICK_W         = 16;

   // ----------------------------------------------------------------
   // Modes
   // ----------------------------------------------------------------
   typedef enum logic {
      VRO_CONTROLLED,
      VRO_RESTRAINED
   } vro_mode_t;

   typedef struct packed {
      vro_mode_t          mode;
      logic [MAG_W-1:0]   base;
      logic [PCT_W-1:0]   pct;
      logic [MAG_W-1:0]   u_low;
      logic [MAG_W-1:0]   u_high;
   } vro_set_t;

endpackage

// ---- vro_phase_if.sv ----
// Per-phase measurement and start flag bundle
`timescale 1ns/1ps
interface vro_phase_if;
   logic [vro_pkg::MAG_W-1:0] voltage;
   logic [vro_pkg::MAG_W-1:0] current;
   logic                      start;

   modport meas (
      output voltage,
      output current,
      input  start
   );

   modport phase (
      input  voltage,
      input  current,
      output start
   );
endinterface

// ---- vro_phase.sv ----
// One phase of the voltage dependent pickup characteristic
`timescale 1ns/1ps
module vro_phase (
   // Clock and reset
   input  wire logic             clk_in,
   input  wire logic             rst_in,
   // Settings and gating
   input  wire vro_pkg::vro_set_t set_in,
   input  wire logic             active_in,
   // Phase bundle
   vro_phase_if.phase            pif
);

   logic [vro_pkg::PROD_W-1:0] reduced;
   logic [vro_pkg::PROD_W-1:0] thr;
   logic [vro_pkg::PROD_W-1:0] slope_prod;
   logic [vro_pkg::MAG_W-1:0]  span;
   logic [vro_pkg::MAG_W-1:0]  off;
   logic                       below_low;
   logic                       at_high;
   logic                       start_cond;
   logic                       start_r;
   logic                       start_nxt;

   // ----------------------------------------------------------------
   // Threshold
   // ----------------------------------------------------------------
   // Combinational divide keeps the flag one cycle behind the sample
   always_comb begin
      below_low  = pif.voltage < set_in.u_low;
      at_high    = pif.voltage >= set_in.u_high;
      reduced    = (vro_pkg::PROD_W'(set_in.base) * vro_pkg::PROD_W'(set_in.pct))
                   / vro_pkg::PROD_W'(vro_pkg::PCT_DIV);
      span       = set_in.u_high - set_in.u_low;
      off        = pif.voltage - set_in.u_low;
      slope_prod = vro_pkg::PROD_W'(set_in.base - reduced[vro_pkg::MAG_W-1:0])
                   * vro_pkg::PROD_W'(off);
      if (below_low) begin
         thr = reduced;
      end else if (at_high || span == '0) begin
         thr = vro_pkg::PROD_W'(set_in.base);
      end else begin
         thr = reduced + slope_prod / vro_pkg::PROD_W'(span);
      end
      if (set_in.mode == vro_pkg::VRO_CONTROLLED) begin
         start_cond = below_low && (pif.current > set_in.base);
      end else begin
         start_cond = vro_pkg::PROD_W'(pif.current) > thr;
      end
      start_nxt = active_in && start_cond;
   end

   always_ff @(posedge clk_in or posedge rst_in) begin
      if (rst_in) begin
         start_r <= 1'b0;
      end else begin
         start_r <= start_nxt;
      end
   end

   assign pif.start = start_r;

   // ----------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------
   a_ctrl_no_high: assert property (@(posedge clk_in) disable iff (rst_in)
      (set_in.mode == vro_pkg::VRO_CONTROLLED && !below_low) |=> !start_r)
      else $error("controlled mode started above lower limit");

   a_restr_high_base: assert property (@(posedge clk_in) disable iff (rst_in)
      (set_in.mode == vro_pkg::VRO_RESTRAINED && at_high && !below_low && active_in
       && pif.current > set_in.base) |=> start_r)
      else $error("restrained start missing above upper limit");

   a_restr_low_thr: assert property (@(posedge clk_in) disable iff (rst_in)
      below_low |-> thr == (vro_pkg::PROD_W'(set_in.base) * vro_pkg::PROD_W'(set_in.pct)) / 100)
      else $error("reduced threshold wrong below lower limit");

   a_phase_start: assert property (@(posedge clk_in) disable iff (rst_in)
      start_r == $past(start_cond && active_in))
      else $error("phase start does not follow its threshold");

   c_between: cover property (@(posedge clk_in) disable iff (rst_in)
      set_in.mode == vro_pkg::VRO_RESTRAINED && !below_low && !at_high ##1 start_r);

endmodule

// ---- vro_top.sv ----
// Voltage restrained overcurrent decision logic: settings, phases, delay, trip
`timescale 1ns/1ps
module vro_top #(
   parameter int MS_TICK = vro_pkg::MS_TICK_CYCLES
) (
   // Clock and reset
   input  wire logic                          clk_in,
   input  wire logic                          rst_in,
   // Measured magnitudes
   input  wire logic [vro_pkg::MAG_W-1:0]     phase1_voltage_in,
   input  wire logic [vro_pkg::MAG_W-1:0]     phase2_voltage_in,
   input  wire logic [vro_pkg::MAG_W-1:0]     phase3_voltage_in,
   input  wire logic [vro_pkg::MAG_W-1:0]     phase1_current_in,
   input  wire logic [vro_pkg::MAG_W-1:0]     phase2_current_in,
   input  wire logic [vro_pkg::MAG_W-1:0]     phase3_current_in,
   // Settings
   input  wire logic                          operation_enable_in,
   input  wire logic                          setting_load_in,
   input  wire logic                          restrain_mode_in,
   input  wire logic [vro_pkg::MAG_W-1:0]     pickup_current_base_in,
   input  wire logic [vro_pkg::PCT_W-1:0]     low_voltage_pickup_percent_in,
   input  wire logic [vro_pkg::MAG_W-1:0]     u_low_limit_in,
   input  wire logic [vro_pkg::MAG_W-1:0]     u_high_limit_in,
   input  wire logic [vro_pkg::DELAY_W-1:0]   time_delay_ms_in,
   // Blocking
   input  wire logic                          user_block_input_in,
   input  wire logic                          vt_failure_block_input_in,
   // Outputs
   output logic                               phase1_start_flag_out,
   output logic                               phase2_start_flag_out,
   output logic                               phase3_start_flag_out,
   output logic                               any_phase_start_flag_out,
   output logic                               function_trip_flag_out,
   output logic                               setting_warning_out
);

   vro_pkg::vro_set_t             set_r;
   vro_pkg::vro_set_t             set_nxt;
   logic [vro_pkg::DELAY_W-1:0]   delay_r;
   logic [vro_pkg::DELAY_W-1:0]   delay_nxt;
   logic                          err_r;
   logic                          err_nxt;
   logic                          active;
   logic                          running;
   logic [vro_pkg::TICK_W-1:0]    tick_r;
   logic [vro_pkg::TICK_W-1:0]    tick_nxt;
   logic [vro_pkg::DELAY_W-1:0]   ms_r;
   logic [vro_pkg::DELAY_W-1:0]   ms_nxt;
   logic                          any_r;
   logic                          any_nxt;
   logic                          trip_r;
   logic                          trip_nxt;

   // Checks that name no clock run on the sample clock, off during reset
   default clocking chk_cb @(posedge clk_in);
   endclocking
   default disable iff (rst_in);

   // ----------------------------------------------------------------
   // Setting load and limit check
   // ----------------------------------------------------------------
   // Limits apply only after a load, so a wrong pair is held off whole
   always_comb begin
      set_nxt   = set_r;
      delay_nxt = delay_r;
      err_nxt   = err_r;
      if (setting_load_in) begin
         set_nxt.mode   = vro_pkg::vro_mode_t'(restrain_mode_in);
         set_nxt.base   = pickup_current_base_in;
         set_nxt.pct    = (low_voltage_pickup_percent_in > vro_pkg::PCT_MAX) ?
                          vro_pkg::PCT_MAX : low_voltage_pickup_percent_in;
         set_nxt.u_low  = u_low_limit_in;
         set_nxt.u_high = u_high_limit_in;
         delay_nxt      = time_delay_ms_in;
         err_nxt        = u_low_limit_in > u_high_limit_in;
      end
   end

   always_ff @(posedge clk_in or posedge rst_in) begin
      if (rst_in) begin
         set_r.mode   <= vro_pkg::VRO_CONTROLLED;
         set_r.base   <= vro_pkg::BASE_RST;
         set_r.pct    <= vro_pkg::PCT_RST;
         set_r.u_low  <= vro_pkg::U_LOW_RST;
         set_r.u_high <= vro_pkg::U_HIGH_RST;
         delay_r      <= vro_pkg::DELAY_RST;
         err_r        <= 1'b0;
      end else begin
         set_r   <= set_nxt;
         delay_r <= delay_nxt;
         err_r   <= err_nxt;
      end
   end

   // Voltage failure block comes from outside supervision logic
   assign active = operation_enable_in && !user_block_input_in
                   && !vt_failure_block_input_in && !err_r;

   // ----------------------------------------------------------------
   // Phases
   // ----------------------------------------------------------------
   vro_phase_if pif1 ();
   vro_phase_if pif2 ();
   vro_phase_if pif3 ();

   assign pif1.voltage = phase1_voltage_in;
   assign pif1.current = phase1_current_in;
   assign pif2.voltage = phase2_voltage_in;
   assign pif2.current = phase2_current_in;
   assign pif3.voltage = phase3_voltage_in;
   assign pif3.current = phase3_current_in;

   vro_phase u_phase1 (
      .clk_in    (clk_in),
      .rst_in    (rst_in),
      .set_in    (set_r),
      .active_in (active),
      .pif       (pif1)
   );

   vro_phase u_phase2 (
      .clk_in    (clk_in),
      .rst_in    (rst_in),
      .set_in    (set_r),
      .active_in (active),
      .pif       (pif2)
   );

   vro_phase u_phase3 (
      .clk_in    (clk_in),
      .rst_in    (rst_in),
      .set_in    (set_r),
      .active_in (active),
      .pif       (pif3)
   );

   // ----------------------------------------------------------------
   // General start and definite delay
   // ----------------------------------------------------------------
   // Delay counts in whole milliseconds; a short drop-out restarts it
   assign running = active && (pif1.start || pif2.start || pif3.start);

   always_comb begin
      any_nxt  = running;
      tick_nxt = '0;
      ms_nxt   = '0;
      trip_nxt = 1'b0;
      if (running) begin
         tick_nxt = tick_r;
         ms_nxt   = ms_r;
         if (ms_r < delay_r) begin
            if (tick_r == vro_pkg::TICK_W'(MS_TICK - 1)) begin
               tick_nxt = '0;
               ms_nxt   = ms_r + 1'b1;
            end else begin
               tick_nxt = tick_r + 1'b1;
            end
         end
         trip_nxt = ms_r >= delay_r;
      end
   end

   always_ff @(posedge clk_in or posedge rst_in) begin
      if (rst_in) begin
         tick_r <= '0;
         ms_r   <= '0;
         any_r  <= 1'b0;
         trip_r <= 1'b0;
      end else begin
         tick_r <= tick_nxt;
         ms_r   <= ms_nxt;
         any_r  <= any_nxt;
         trip_r <= trip_nxt;
      end
   end

   // ----------------------------------------------------------------
   // Outputs
   // ----------------------------------------------------------------
   assign phase1_start_flag_out    = pif1.start;
   assign phase2_start_flag_out    = pif2.start;
   assign phase3_start_flag_out    = pif3.start;
   assign any_phase_start_flag_out = any_r;
   assign function_trip_flag_out   = trip_r;
   assign setting_warning_out      = err_r;

   // ----------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------
   a_block_quiets_all: assert property (@(posedge clk_in) disable iff (rst_in)
      (user_block_input_in || vt_failure_block_input_in) |=>
      !phase1_start_flag_out && !phase2_start_flag_out && !phase3_start_flag_out
      && !function_trip_flag_out)
      else $error("output active while blocked");

   a_enable_needed: assert property (@(posedge clk_in) disable iff (rst_in)
      !operation_enable_in |=> !any_r && !trip_r && !pif1.start)
      else $error("output active while function disabled");

   a_general_or: assert property (@(posedge clk_in) disable iff (rst_in)
      any_r == $past(active && (pif1.start || pif2.start || pif3.start)))
      else $error("general start is not the or of phase starts");

   a_inactive_quiet: assert property (!active |=>
      !phase2_start_flag_out && !phase3_start_flag_out)
      else $error("phase start while function inactive");

   a_enable_phases: assert property (!operation_enable_in |=>
      !phase2_start_flag_out && !phase3_start_flag_out)
      else $error("phase start while function disabled");

   a_block_quiets_any: assert property (
      (user_block_input_in || vt_failure_block_input_in) |=> !any_phase_start_flag_out)
      else $error("general start while blocked");

   a_any_follows: assert property (
      (active && phase2_start_flag_out) |=> any_phase_start_flag_out)
      else $error("general start missing after phase start");

   a_any_needs_phase: assert property (any_phase_start_flag_out |->
      $past(phase1_start_flag_out || phase2_start_flag_out || phase3_start_flag_out))
      else $error("general start without phase start");

   a_timer_clear: assert property (@(posedge clk_in) disable iff (rst_in)
      !running |=> ms_r == '0 && tick_r == '0 && !trip_r)
      else $error("delay timer not cleared without start");

   // ----------------------------------------------------------------
   // Setting checks
   // ----------------------------------------------------------------
   a_warn_on_bad: assert property (@(posedge clk_in) disable iff (rst_in)
      (setting_load_in && u_low_limit_in > u_high_limit_in) |=> setting_warning_out
      ##1 (!setting_warning_out || !trip_r))
      else $error("bad limit pair not flagged");

   a_warn_holds: assert property (@(posedge clk_in) disable iff (rst_in)
      (setting_warning_out && !setting_load_in) |=> setting_warning_out)
      else $error("warning left without a corrected load");

   a_warn_blocks: assert property (@(posedge clk_in) disable iff (rst_in)
      setting_warning_out |=> !phase1_start_flag_out && !any_phase_start_flag_out)
      else $error("start while setting warning shown");

   a_equal_ok: assert property (@(posedge clk_in) disable iff (rst_in)
      (setting_load_in && u_low_limit_in == u_high_limit_in) |=> !setting_warning_out)
      else $error("equal limits rejected");

   a_warn_clear: assert property (
      (setting_load_in && u_low_limit_in <= u_high_limit_in) |=> !setting_warning_out)
      else $error("warning kept after good load");

   a_warn_only_load: assert property (
      $rose(setting_warning_out) |-> $past(setting_load_in))
      else $error("warning raised without a load");

   a_pct_clamp: assert property (
      setting_load_in |=> set_r.pct <= vro_pkg::PCT_MAX)
      else $error("percent not clamped");

   a_delay_loaded: assert property (
      setting_load_in |=> delay_r == $past(time_delay_ms_in))
      else $error("delay not taken on load");

   // ----------------------------------------------------------------
   // Delay checks
   // ----------------------------------------------------------------
   a_zero_delay: assert property (@(posedge clk_in) disable iff (rst_in)
      (running && delay_r == '0) |=> function_trip_flag_out)
      else $error("zero delay did not trip at once");

   a_trip_cause: assert property (@(posedge clk_in) disable iff (rst_in)
      function_trip_flag_out |-> $past(running) && $past(ms_r) >= $past(delay_r))
      else $error("trip without expired delay");

   a_one_ms_step: assert property (@(posedge clk_in) disable iff (rst_in)
      (running && ms_r < delay_r && tick_r == vro_pkg::TICK_W'(MS_TICK - 1))
      |=> (ms_r == $past(ms_r) + 1'b1 || !$past(running)))
      else $error("millisecond count did not advance");

   a_tick_bound: assert property (
      tick_r < vro_pkg::TICK_W'(MS_TICK))
      else $error("millisecond prescaler overran");

   a_ms_hold: assert property (
      (running && ms_r >= delay_r) |=> ms_r == $past(ms_r))
      else $error("millisecond count moved after expiry");

   a_no_trip_early: assert property (
      (running && ms_r < delay_r) |=> !function_trip_flag_out)
      else $error("trip before delay expired");

   a_trip_with_any: assert property (
      function_trip_flag_out |-> any_phase_start_flag_out)
      else $error("trip without general start");

   // ----------------------------------------------------------------
   // Coverage
   // ----------------------------------------------------------------
   c_trip: cover property (@(posedge clk_in) disable iff (rst_in)
      any_phase_start_flag_out ##1 function_trip_flag_out);

   c_warning: cover property (@(posedge clk_in) disable iff (rst_in)
      $rose(setting_warning_out));

   c_recover: cover property (@(posedge clk_in) disable iff (rst_in)
      $fell(setting_warning_out));

   c_blocked: cover property (@(posedge clk_in) disable iff (rst_in)
      any_phase_start_flag_out ##1 vt_failure_block_input_in ##1 !any_phase_start_flag_out);

endmodule

// ---- vro_meas_model.sv ----
// Measurement front end and user blocking logic driving the overcurrent block
`timescale 1ns/1ps
module vro_meas_model (
   // Clock
   input  wire logic                         clk_in,
   // Measured magnitudes, index 0 is phase 1
   output logic [2:0][vro_pkg::MAG_W-1:0]    volt_out,
   output logic [2:0][vro_pkg::MAG_W-1:0]    curr_out,
   // Blocking equations
   output logic                              user_block_out,
   output logic                              vt_block_out
);
   // ----------------------------------------------------------------
   // Quiet start: no fault, no block
   // ----------------------------------------------------------------
   initial begin
      volt_out       = '0;
      curr_out       = '0;
      user_block_out = 1'b0;
      vt_block_out   = 1'b0;
   end

   // ----------------------------------------------------------------
   // Measurement and block updates, all changed on one edge
   // ----------------------------------------------------------------
   task automatic set_meas(input logic [2:0][vro_pkg::MAG_W-1:0] v,
                           input logic [2:0][vro_pkg::MAG_W-1:0] i);
      @(posedge clk_in);
      volt_out <= v;
      curr_out <= i;
   endtask

   task automatic set_block(input logic u);
      @(posedge clk_in);
      user_block_out <= u;
   endtask

   // Lost voltage reads as zero, which alone would lower the pickup
   task automatic vt_fail(input logic on);
      @(posedge clk_in);
      vt_block_out <= on;
      if (on) begin
         volt_out <= '0;
      end
   endtask
endmodule

// ---- tb_vro_top.sv ----
// Self-checking testbench of the voltage restrained overcurrent block
`timescale 1ns/1ps
module tb_vro_top;
   // ----------------------------------------------------------------
   // Signals
   // ----------------------------------------------------------------
   localparam int TICK = 4;
   logic                                clk_in;
   logic                                rst_in;
   logic                                enable;
   logic                                load;
   logic                                mode;
   logic [vro_pkg::MAG_W-1:0]           base;
   logic [vro_pkg::PCT_W-1:0]           pct;
   logic [vro_pkg::MAG_W-1:0]           ulo;
   logic [vro_pkg::MAG_W-1:0]           uhi;
   logic [vro_pkg::DELAY_W-1:0]         dly;
   logic [2:0][vro_pkg::MAG_W-1:0]      volt;
   logic [2:0][vro_pkg::MAG_W-1:0]      curr;
   logic                                ublk;
   logic                                vtblk;
   logic [2:0]                          st;
   logic                                any;
   logic                                trip;
   logic                                warn;
   int                                  n_errors;
   int                                  tests_run;
   int                                  cycles = 0;
   int                                  k;

   vro_meas_model meas_i (
      .clk_in         (clk_in),
      .volt_out       (volt),
      .curr_out       (curr),
      .user_block_out (ublk),
      .vt_block_out   (vtblk)
   );

   vro_top #(.MS_TICK(TICK)) vro_top_i (
      .clk_in                        (clk_in),
      .rst_in                        (rst_in),
      .phase1_voltage_in             (volt[0]),
      .phase2_voltage_in             (volt[1]),
      .phase3_voltage_in             (volt[2]),
      .phase1_current_in             (curr[0]),
      .phase2_current_in             (curr[1]),
      .phase3_current_in             (curr[2]),
      .operation_enable_in           (enable),
      .setting_load_in               (load),
      .restrain_mode_in              (mode),
      .pickup_current_base_in        (base),
      .low_voltage_pickup_percent_in (pct),
      .u_low_limit_in                (ulo),
      .u_high_limit_in               (uhi),
      .time_delay_ms_in              (dly),
      .user_block_input_in           (ublk),
      .vt_failure_block_input_in     (vtblk),
      .phase1_start_flag_out         (st[0]),
      .phase2_start_flag_out         (st[1]),
      .phase3_start_flag_out         (st[2]),
      .any_phase_start_flag_out      (any),
      .function_trip_flag_out        (trip),
      .setting_warning_out           (warn)
   );

   // ----------------------------------------------------------------
   // Clock, timeout and shared tasks
   // ----------------------------------------------------------------
   initial begin
      clk_in = 1'b0;
      forever #10 clk_in = ~clk_in;
   end

   // Whole run needs well under two thousand cycles
   always @(posedge clk_in) begin
      cycles <= cycles + 1;
      if (cycles == 20000) begin
         n_errors = n_errors + 1;
         test_done();
      end
   end

   task automatic test_done();
      if (n_errors == 0 && tests_run > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask

   task automatic check(input string name, input logic seen, input logic exp);
      tests_run = tests_run + 1;
      if (seen !== exp) begin
         n_errors = n_errors + 1;
         $display("mismatch %s expected %b seen %b", name, exp, seen);
      end
   endtask

   task automatic put(input logic m, input logic [15:0] b, input logic [6:0] p,
                      input logic [15:0] lo, input logic [15:0] hi, input logic [15:0] d);
      @(posedge clk_in);
      mode <= m;
      base <= b;
      pct  <= p;
      ulo  <= lo;
      uhi  <= hi;
      dly  <= d;
      load <= 1'b1;
      @(posedge clk_in);
      load <= 1'b0;
   endtask

   // Levels settle within three cycles of the last input change
   task automatic expect_out(input logic [2:0] s, input logic t, input logic w);
      repeat (4) @(posedge clk_in);
      #1;
      check("phase1_start", st[0], s[0]);
      check("phase2_start", st[1], s[1]);
      check("phase3_start", st[2], s[2]);
      check("any_start", any, |s);
      check("trip", trip, t);
      check("warning", warn, w);
   endtask

   // Trip is due two milliseconds of ticks plus one cycle after the flag
   task automatic timed_trip();
      meas_i.set_meas({16'h1388, 16'h1388, 16'h0fa0}, {16'h0000, 16'h0000, 16'h07d0});
      for (k = 0; k < 4 && st[0] !== 1'b1; k++) @(posedge clk_in);
      repeat (7) @(posedge clk_in);
      #1;
      check("trip_early", trip, 1'b0);
      @(posedge clk_in);
      #1;
      check("trip_late", trip, 1'b1);
   endtask

   // ----------------------------------------------------------------
   // Main sequence
   // ----------------------------------------------------------------
   initial begin
      n_errors  = 0;
      tests_run = 0;
      rst_in    = 1'b1;
      enable    = 1'b1;
      load      = 1'b0;
      mode      = 1'b0;
      base      = '0;
      pct       = '0;
      ulo       = '0;
      uhi       = '0;
      dly       = '0;
      repeat (6) @(posedge clk_in);
      rst_in <= 1'b0;
      // Controlled: only under low limit and strictly over base
      put(1'b0, 16'h03e8, 7'h32, 16'h1388, 16'h1f40, 16'h0000);
      meas_i.set_meas({16'h0064, 16'h1388, 16'h1387}, {16'h03e8, 16'h07d0, 16'h03e9});
      expect_out(3'b001, 1'b1, 1'b0);
      // Restrained: reduced 500, mid 750, base 1000 at high limit
      put(1'b1, 16'h03e8, 7'h32, 16'h0fa0, 16'h1f40, 16'h0000);
      meas_i.set_meas({16'h1f40, 16'h1770, 16'h0f9f}, {16'h03e8, 16'h02ef, 16'h01f5});
      expect_out(3'b011, 1'b1, 1'b0);
      meas_i.set_meas({16'h1f40, 16'h1770, 16'h0f9f}, {16'h03e9, 16'h02ed, 16'h01f4});
      expect_out(3'b100, 1'b1, 1'b0);
      // Equal limits: step at 5000
      put(1'b1, 16'h03e8, 7'h32, 16'h1388, 16'h1388, 16'h0000);
      meas_i.set_meas({16'h1388, 16'h1388, 16'h1387}, {16'h03e9, 16'h01f5, 16'h01f5});
      expect_out(3'b101, 1'b1, 1'b0);
      // Bad limits block, corrected load restores
      put(1'b1, 16'h03e8, 7'h32, 16'h1389, 16'h1388, 16'h0000);
      expect_out(3'b000, 1'b0, 1'b1);
      put(1'b1, 16'h03e8, 7'h32, 16'h1388, 16'h1388, 16'h0000);
      expect_out(3'b101, 1'b1, 1'b0);
      // Enable and both blocks
      @(posedge clk_in) enable <= 1'b0;
      expect_out(3'b000, 1'b0, 1'b0);
      @(posedge clk_in) enable <= 1'b1;
      meas_i.set_block(1'b1);
      expect_out(3'b000, 1'b0, 1'b0);
      meas_i.set_block(1'b0);
      expect_out(3'b101, 1'b1, 1'b0);
      meas_i.vt_fail(1'b1);
      expect_out(3'b000, 1'b0, 1'b0);
      meas_i.vt_fail(1'b0);
      // Delay of 2 ms; a short start must clear the timer
      put(1'b1, 16'h03e8, 7'h32, 16'h0fa0, 16'h1f40, 16'h0002);
      meas_i.set_meas('0, '0);
      expect_out(3'b000, 1'b0, 1'b0);
      meas_i.set_meas({16'h1388, 16'h1388, 16'h0fa0}, {16'h0000, 16'h0000, 16'h07d0});
      repeat (6) @(posedge clk_in);
      meas_i.set_meas('0, '0);
      repeat (4) @(posedge clk_in);
      timed_trip();
      meas_i.set_meas('0, '0);
      expect_out(3'b000, 1'b0, 1'b0);
      test_done();
   end
endmodule
